/* File: eeprom_regs.svh */
// Purpose: shared constants of the two-wire serial memory and its master
// Assumes: link-side oversampling clock of 32 ns, system clock of 10 ns
// Notes: definitions only
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// device type identifier in the select byte; value is arbitrary
`define TYPE_ID 4'h5
`define SEL_TYPE_MSB 7
`define SEL_TYPE_LSB 4
`define SEL_STRAP_MSB 3
`define SEL_STRAP_LSB 1
`define SEL_DIR_BIT 0

`define MEM_ADDR_W 8
`define PAGE_BITS 4
`define PAGE_BYTES 16
`define ACK_SLOT 8
`define LAST_SLOT 9
`define RESET_BYTE 8'h00

`define CLK_PERIOD_NS 10
`define LINK_PERIOD_NS 32
`define GLITCH_NS 100
// a glitch of the full width can cover this many samples, so wait one more
`define GLITCH_CYCLES (`GLITCH_NS / `LINK_PERIOD_NS + 2)
`define WRITE_CYCLE_MS 5
`define WRITE_CYCLES (`WRITE_CYCLE_MS * 1000000 / `LINK_PERIOD_NS)
`define SCL_PERIOD_NS 2500
`define SCL_QUARTER_CYCLES \
	((`SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: eeprom_pkg.sv */
// Purpose: types shared by both ends of the two-wire memory link
// Assumes: nothing
// Notes: constants live in eeprom_regs.svh
package eeprom_pkg;

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_SELECT = 3'b001,
		D_ADDR = 3'b010,
		D_WDATA = 3'b011,
		D_RDATA = 3'b100,
		D_WRITING = 3'b101
	} dev_state_t;

	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_START = 2'b01,
		M_BIT = 2'b10,
		M_STOP = 2'b11
	} mst_state_t;

	typedef enum logic [2:0] {
		ST_SEL_W = 3'b000,
		ST_ADDR = 3'b001,
		ST_WDATA = 3'b010,
		ST_SEL_R = 3'b011,
		ST_RDATA = 3'b100
	} mst_step_t;

	typedef enum logic [1:0] {
		CMD_WRITE = 2'b00,
		CMD_RANDOM_READ = 2'b01,
		CMD_CURRENT_READ = 2'b10,
		CMD_POLL = 2'b11
	} cmd_kind_t;

endpackage : eeprom_pkg

/* File: two_wire_if.sv */
// Purpose: open-drain serial clock and data wires between master and memory
// Assumes: external pull-ups, so a released wire reads high
// Notes: an output enable is low while its owner drives the wire
`timescale 1ns/100ps
interface two_wire_if;
	logic m_scl_out;
	logic m_scl_oe_n;
	logic m_sda_out;
	logic m_sda_oe_n;
	logic d_sda_out;
	logic d_sda_oe_n;
	logic scl;
	logic sda;

	assign scl = m_scl_oe_n | m_scl_out;
	assign sda = (m_sda_oe_n | m_sda_out) & (d_sda_oe_n | d_sda_out);

	modport master (
		output m_scl_out,
		output m_scl_oe_n,
		output m_sda_out,
		output m_sda_oe_n,
		input scl,
		input sda
	);

	modport device (
		output d_sda_out,
		output d_sda_oe_n,
		input scl,
		input sda
	);
endinterface : two_wire_if

/* File: line_filter.sv */
// Purpose: two-flop synchroniser followed by a stability filter
// Assumes: i_d is asynchronous to i_clk
// Notes: STABLE of 1 gives a plain synchroniser
`timescale 1ns/100ps
module line_filter #(
	parameter int WIDTH = 1,
	parameter int STABLE = 1,
	parameter logic [WIDTH-1:0] RESET = '1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// raw and filtered level
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	localparam int CW = $clog2(STABLE + 1);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] sync;
	logic [CW-1:0] cnt;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta <= RESET;
			sync <= RESET;
		end else begin
			meta <= i_d;
			sync <= meta;
		end
	end

	// a change is taken only after STABLE equal samples in a row
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_q <= RESET;
			cnt <= '0;
		end else if (sync == o_q) begin
			cnt <= '0;
		end else if (cnt == CW'(STABLE - 1)) begin
			o_q <= sync;
			cnt <= '0;
		end else begin
			cnt <= cnt + CW'(1);
		end
	end
endmodule : line_filter

/* File: eeprom_device.sv */
// Purpose: slave end of a two-wire serial memory with page write and reads
// Assumes: I_LINK_CLK free-running oversampling clock; master drives SCL
// Notes: write cycle timer is shortened in simulation via WRITE_CYCLES
//
// Function
// - page of sixteen bytes committed in one cycle
// - master keeps writes inside the addressed row
// - ack each data byte when unprotected
// - protected write nacks data, memory unchanged
// - only low four address bits advance on write
// - master ends page write with stop
// - write cycle leaves bus, commits latched page
// - busy device nacks select, master repeats poll
// - after write cycle, select acked, instruction continues
// - random read keeps same seven select bits
// - reads ignore the write protect level
// - dummy write loads address, restart then reads
// - random read byte acked select, master nacks
// - current read outputs counter byte, then increments
// - master ack requests next sequential byte
// - address counter wraps to zero when reading
// - no ack in ninth bit ends read
// - glitches up to 100 ns ignored
// - select carries type, straps, direction; ack on match
// - write cycle starts only on stop after ack
// - protect sampled from start through address byte
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module eeprom_device
	import eeprom_pkg::*;
#(
	parameter int ADDR_W = `MEM_ADDR_W,
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// system clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	// link oversampling clock
	input wire logic I_LINK_CLK,
	// pins
	input wire logic I_WRITE_PROTECT,
	input wire logic [2:0] I_CHIP_ENABLE_STRAPS,
	// status in the system clock domain
	output logic O_BUSY,
	// serial bus
	two_wire_if.device bus
);
	localparam int PB = `PAGE_BITS;
	localparam int NP = `PAGE_BYTES;
	localparam int TW = $clog2(WRITE_CYCLES + 1);

	logic rst_meta;
	logic rst_link;
	logic scl_f;
	logic sda_f;
	logic scl_p;
	logic sda_p;
	logic wp;
	logic [2:0] straps;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic sel_match;
	logic go_write;
	logic wr_done;
	dev_state_t state;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic [7:0] rbyte;
	logic [7:0] mem_rd;
	logic [ADDR_W-1:0] addr;
	logic protect;
	logic drive;
	logic [TW-1:0] timer;
	logic [7:0] page [NP];
	logic [NP-1:0] page_vld;
	logic [7:0] mem [2**ADDR_W];
	logic busy_link;
	logic busy_meta;

	// link-domain reset; the first flop feeds only the second
	always_ff @(posedge I_LINK_CLK) begin
		rst_meta <= I_RST_N;
		rst_link <= rst_meta;
	end

	line_filter #(.WIDTH(1), .STABLE(`GLITCH_CYCLES), .RESET(1'b1)) u_scl (
		.i_clk(I_LINK_CLK),
		.i_rst_n(rst_link),
		.i_d(bus.scl),
		.o_q(scl_f)
	);

	line_filter #(.WIDTH(1), .STABLE(`GLITCH_CYCLES), .RESET(1'b1)) u_sda (
		.i_clk(I_LINK_CLK),
		.i_rst_n(rst_link),
		.i_d(bus.sda),
		.o_q(sda_f)
	);

	line_filter #(.WIDTH(4), .STABLE(1), .RESET(4'h0)) u_pins (
		.i_clk(I_LINK_CLK),
		.i_rst_n(rst_link),
		.i_d({I_WRITE_PROTECT, I_CHIP_ENABLE_STRAPS}),
		.o_q({wp, straps})
	);

	always_ff @(posedge I_LINK_CLK) begin
		if (!rst_link) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_p;
	assign scl_fall = ~scl_f & scl_p;
	assign start = scl_f & scl_p & sda_p & ~sda_f;
	assign stop = scl_f & scl_p & ~sda_p & sda_f;
	assign sel_match = (shreg[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == `TYPE_ID) &&
		(shreg[`SEL_STRAP_MSB:`SEL_STRAP_LSB] == straps);
	// stop in the first slot after a data ack, with data latched
	assign go_write = stop && state == D_WDATA && bitcnt == 4'd1 &&
		!protect && |page_vld;
	assign wr_done = state == D_WRITING && timer == '0;
	assign mem_rd = mem[addr];

	always_ff @(posedge I_LINK_CLK) begin
		if (!rst_link) begin
			state <= D_IDLE;
			bitcnt <= 4'h0;
			shreg <= `RESET_BYTE;
			rbyte <= `RESET_BYTE;
			addr <= '0;
			protect <= 1'b0;
			drive <= 1'b0;
		end else if (state == D_WRITING) begin
			// bus ignored, so every select meets a released line
			drive <= 1'b0;
			if (wr_done) begin
				state <= D_IDLE;
			end
		end else if (start) begin
			state <= D_SELECT;
			bitcnt <= 4'h0;
			drive <= 1'b0;
			protect <= wp;
		end else if (stop) begin
			drive <= 1'b0;
			state <= go_write ? D_WRITING : D_IDLE;
		end else if (state != D_IDLE) begin
			if (state == D_SELECT || state == D_ADDR) begin
				protect <= protect | wp;
			end
			if (scl_rise) begin
				if (bitcnt != `LAST_SLOT) begin
					bitcnt <= bitcnt + 4'd1;
				end
				if (bitcnt < `ACK_SLOT && state != D_RDATA) begin
					shreg <= {shreg[6:0], sda_f};
				end
				if (bitcnt == `ACK_SLOT && state == D_RDATA && sda_f) begin
					state <= D_IDLE;
				end
			end else if (scl_fall && bitcnt == `ACK_SLOT) begin
				case (state)
					D_SELECT: begin
						if (sel_match) begin
							drive <= 1'b1;
						end else begin
							state <= D_IDLE;
						end
					end
					D_ADDR: begin
						drive <= 1'b1;
						addr <= ADDR_W'(shreg);
					end
					D_WDATA: begin
						drive <= !protect;
						addr[PB-1:0] <= addr[PB-1:0] + PB'(1);
					end
					default: begin
						drive <= 1'b0;
					end
				endcase
			end else if (scl_fall && bitcnt == `LAST_SLOT) begin
				bitcnt <= 4'h0;
				drive <= 1'b0;
				if ((state == D_SELECT && shreg[`SEL_DIR_BIT]) ||
					state == D_RDATA) begin
					// protect is not consulted on the read path
					state <= D_RDATA;
					rbyte <= {mem_rd[6:0], 1'b0};
					drive <= !mem_rd[7];
					addr <= addr + ADDR_W'(1);
				end else if (state == D_SELECT) begin
					state <= D_ADDR;
				end else if (state == D_ADDR) begin
					state <= D_WDATA;
				end
			end else if (scl_fall && state == D_RDATA && bitcnt != 4'h0) begin
				drive <= !rbyte[7];
				rbyte <= {rbyte[6:0], 1'b0};
			end
		end
	end

	// page latch; a long burst wraps within the row and overwrites
	always_ff @(posedge I_LINK_CLK) begin
		if (!rst_link) begin
			page_vld <= '0;
			for (int i = 0; i < NP; i++) begin
				page[i] <= `RESET_BYTE;
			end
		end else if (wr_done || (state == D_ADDR && scl_fall &&
			bitcnt == `ACK_SLOT)) begin
			page_vld <= '0;
		end else if (state == D_WDATA && scl_fall && bitcnt == `ACK_SLOT &&
			!protect && !start && !stop) begin
			page[addr[PB-1:0]] <= shreg;
			page_vld[addr[PB-1:0]] <= 1'b1;
		end
	end

	// every latched page byte lands in one cycle at the end of the write time
	always_ff @(posedge I_LINK_CLK) begin
		if (!rst_link) begin
			for (int j = 0; j < 2**ADDR_W; j++) begin
				mem[j] <= `RESET_BYTE;
			end
		end else if (wr_done) begin
			for (int i = 0; i < NP; i++) begin
				if (page_vld[i]) begin
					mem[{addr[ADDR_W-1:PB], PB'(i)}] <= page[i];
				end
			end
		end
	end

	always_ff @(posedge I_LINK_CLK) begin
		if (!rst_link) begin
			timer <= '0;
		end else if (go_write) begin
			timer <= TW'(WRITE_CYCLES - 1);
		end else if (state == D_WRITING && timer != '0) begin
			timer <= timer - TW'(1);
		end
	end

	always_ff @(posedge I_LINK_CLK) begin
		if (!rst_link) begin
			busy_link <= 1'b0;
		end else begin
			busy_link <= state == D_WRITING;
		end
	end

	// level crossing into the system clock
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			busy_meta <= 1'b0;
			O_BUSY <= 1'b0;
		end else begin
			busy_meta <= busy_link;
			O_BUSY <= busy_meta;
		end
	end
	assign bus.d_sda_out = 1'b0;
	assign bus.d_sda_oe_n = !drive;
endmodule : eeprom_device

/* File: eeprom_master.sv */
// Purpose: bus master that drives the serial clock and runs memory commands
// Assumes: single clock I_CLOCK; serial clock derived by a divider
// Notes: write length is clipped at the end of the addressed row
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module eeprom_master
	import eeprom_pkg::*;
#(
	parameter int QUARTER = `SCL_QUARTER_CYCLES
) (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	// command
	input wire logic I_CMD_VALID,
	input wire logic [1:0] I_CMD_KIND,
	input wire logic [6:0] I_CMD_SEL,
	input wire logic [7:0] I_CMD_ADDR,
	input wire logic [4:0] I_CMD_LEN,
	output logic O_CMD_READY,
	// write data
	input wire logic [7:0] I_WDATA,
	output logic O_WDATA_TAKE,
	// read data and status
	output logic [7:0] O_RDATA,
	output logic O_RDATA_VALID,
	output logic O_NACK,
	output logic O_DONE,
	// serial bus
	two_wire_if.master bus
);
	localparam int QW = $clog2(QUARTER + 1);

	mst_state_t state;
	mst_step_t step;
	cmd_kind_t kind;
	logic [QW-1:0] qcnt;
	logic tick;
	logic [1:0] phase;
	logic [3:0] bitn;
	logic [7:0] tx;
	logic [7:0] rx;
	logic [6:0] sel;
	logic [7:0] addr;
	logic [4:0] remain;
	logic [4:0] room;
	logic nak;
	logic scl_low;
	logic sda_low;
	logic sda_in;

	line_filter #(.WIDTH(1), .STABLE(1), .RESET(1'b1)) u_sda (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_d(bus.sda),
		.o_q(sda_in)
	);

	assign tick = qcnt == QW'(QUARTER - 1);
	assign room = 5'(`PAGE_BYTES) - {1'b0, I_CMD_ADDR[3:0]};

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N || state == M_IDLE || tick) begin
			qcnt <= '0;
		end else begin
			qcnt <= qcnt + QW'(1);
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			state <= M_IDLE;
			step <= ST_SEL_W;
			kind <= CMD_WRITE;
			phase <= 2'd0;
			bitn <= 4'h0;
			tx <= `RESET_BYTE;
			rx <= `RESET_BYTE;
			sel <= 7'h00;
			addr <= `RESET_BYTE;
			remain <= 5'h01;
			nak <= 1'b0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			O_CMD_READY <= 1'b1;
			O_WDATA_TAKE <= 1'b0;
			O_RDATA <= `RESET_BYTE;
			O_RDATA_VALID <= 1'b0;
			O_NACK <= 1'b0;
			O_DONE <= 1'b0;
		end else begin
			O_WDATA_TAKE <= 1'b0;
			O_RDATA_VALID <= 1'b0;
			O_DONE <= 1'b0;
			if (state != M_IDLE && tick) begin
				phase <= phase + 2'd1;
			end
			case (state)
				M_IDLE: begin
					phase <= 2'd0;
					if (I_CMD_VALID && O_CMD_READY) begin
						O_CMD_READY <= 1'b0;
						O_NACK <= 1'b0;
						nak <= 1'b0;
						kind <= cmd_kind_t'(I_CMD_KIND);
						sel <= I_CMD_SEL;
						addr <= I_CMD_ADDR;
						remain <= (I_CMD_LEN == 5'h00) ? 5'h01 : I_CMD_LEN;
						if (I_CMD_KIND == CMD_WRITE && I_CMD_LEN > room) begin
							remain <= room;
						end
						step <= (I_CMD_KIND == CMD_CURRENT_READ) ?
							ST_SEL_R : ST_SEL_W;
						state <= M_START;
					end
				end
				M_START: if (tick) begin
					case (phase)
						2'd0: sda_low <= 1'b0;
						2'd1: scl_low <= 1'b0;
						2'd2: sda_low <= 1'b1;
						default: begin
							scl_low <= 1'b1;
							bitn <= 4'h0;
							// same seven bits for both select bytes
							tx <= {sel, step == ST_SEL_R};
							state <= M_BIT;
						end
					endcase
				end
				M_BIT: if (tick) begin
					case (phase)
						2'd0: begin
							if (bitn == `ACK_SLOT) begin
								sda_low <= step == ST_RDATA &&
									remain != 5'h01;
							end else if (step == ST_RDATA) begin
								sda_low <= 1'b0;
							end else begin
								sda_low <= !tx[7];
								tx <= {tx[6:0], 1'b0};
							end
						end
						2'd1: scl_low <= 1'b0;
						2'd2: begin
							if (bitn == `ACK_SLOT) begin
								nak <= sda_in;
							end else begin
								rx <= {rx[6:0], sda_in};
							end
						end
						default: begin
							scl_low <= 1'b1;
							bitn <= bitn + 4'd1;
							if (bitn == `ACK_SLOT) begin
								bitn <= 4'h0;
								if (step != ST_RDATA && nak) begin
									O_NACK <= 1'b1;
									state <= M_STOP;
								end else begin
									case (step)
										ST_SEL_W: begin
											if (kind == CMD_POLL) begin
												state <= M_STOP;
											end else begin
												step <= ST_ADDR;
												tx <= addr;
											end
										end
										ST_ADDR: begin
											if (kind == CMD_WRITE) begin
												step <= ST_WDATA;
												tx <= I_WDATA;
												O_WDATA_TAKE <= 1'b1;
											end else begin
												step <= ST_SEL_R;
												state <= M_START;
											end
										end
										ST_WDATA: begin
											if (remain == 5'h01) begin
												state <= M_STOP;
											end else begin
												remain <= remain - 5'h01;
												tx <= I_WDATA;
												O_WDATA_TAKE <= 1'b1;
											end
										end
										ST_SEL_R: step <= ST_RDATA;
										default: begin
											O_RDATA <= rx;
											O_RDATA_VALID <= 1'b1;
											remain <= remain - 5'h01;
											if (remain == 5'h01) begin
												state <= M_STOP;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
				default: if (tick) begin
					case (phase)
						2'd0: sda_low <= 1'b1;
						2'd1: scl_low <= 1'b0;
						2'd2: sda_low <= 1'b0;
						default: begin
							state <= M_IDLE;
							O_DONE <= 1'b1;
							O_CMD_READY <= 1'b1;
						end
					endcase
				end
			endcase
		end
	end

	assign bus.m_scl_out = 1'b0;
	assign bus.m_scl_oe_n = !scl_low;
	assign bus.m_sda_out = 1'b0;
	assign bus.m_sda_oe_n = !sda_low;
endmodule : eeprom_master

/* File: eeprom_link_sva.sv */
// Purpose: wire-level checks between the memory end and its master
// Assumes: pulled-up wires sampled by the system clock, QUARTER of 20
// Notes: busy length window is derived from WRITE_CYCLES at 32 ns
`timescale 1ns/100ps
module eeprom_link_sva #(
	parameter int WRITE_CYCLES = 800
) (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	// watched signals
	input wire logic O_BUSY,
	input wire logic m_sda_oe_n,
	input wire logic d_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	localparam int BUSY_MIN = WRITE_CYCLES * 3;
	localparam int BUSY_MAX = WRITE_CYCLES * 4;
	int low_age;
	int stop_age;
	int busy_len;
	logic scl_q;
	logic sda_q;

	default clocking dc @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);

	sequence start_seen;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_seen;
		scl && $past(scl) && $rose(sda);
	endsequence

	always_ff @(posedge I_CLOCK) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	always_ff @(posedge I_CLOCK) begin
		low_age <= (!I_RST_N || scl) ? 0 : low_age + 1;
	end
	// saturates so an old stop never looks recent
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) stop_age <= 1000;
		else if (scl && scl_q && sda && !sda_q) stop_age <= 0;
		else if (stop_age < 1000) stop_age <= stop_age + 1;
	end
	always_ff @(posedge I_CLOCK) begin
		busy_len <= (I_RST_N && O_BUSY) ? busy_len + 1 : 0;
	end

	a_drive_after_fall: assert property (
		$changed(d_sda_oe_n) |-> !scl && low_age <= 40)
		else $error("device data drive moved outside the low phase");
	a_busy_quiet_bus: assert property (
		O_BUSY |-> d_sda_oe_n)
		else $error("device drove the data line while busy");
	a_busy_length_window: assert property (
		$fell(O_BUSY) |-> busy_len >= BUSY_MIN && busy_len <= BUSY_MAX)
		else $error("write cycle length out of window");
	a_busy_after_stop: assert property (
		$rose(O_BUSY) |-> stop_age <= 60 && scl && sda)
		else $error("write cycle began without a fresh stop");
	a_release_after_stop: assert property (
		stop_seen |=> d_sda_oe_n [*8])
		else $error("device held the data line after stop");
	a_start_by_master: assert property (
		start_seen |-> !m_sda_oe_n)
		else $error("start not made by the master");
	a_clock_high_width: assert property (
		$rose(scl) |-> scl [*8])
		else $error("serial clock high pulse too short");
	a_bit_held_stable: assert property (
		$rose(scl) |-> ##1 $stable(sda) [*4])
		else $error("data line moved right after clock rise");
endmodule : eeprom_link_sva

/* File: serial_eeprom_page_write_read_bench.sv */
// Purpose: runs master commands against the memory end over the wires
// Assumes: QUARTER 20 and a short write cycle keep the run brief
// Notes: master clips writes at the row end, so row wrap is not reachable
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module serial_eeprom_page_write_read_bench
	import eeprom_pkg::*;
();
	localparam int WCYC = 800;
	localparam logic [2:0] STRAPS = 3'b101;
	localparam logic [6:0] SEL = {`TYPE_ID, STRAPS};
	logic I_CLOCK = 1'b0;
	logic I_LINK_CLK = 1'b0;
	logic I_RST_N = 1'b0;
	logic wp = 1'b0;
	logic valid = 1'b0;
	logic [1:0] kind = 2'b00;
	logic [6:0] sel = SEL;
	logic [7:0] addr = 8'h00;
	logic [4:0] len = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic ready, take, rvalid, nack, done, busy;
	logic [7:0] rdata;
	logic [7:0] wbuf [16];
	logic [7:0] got [$];
	int num_errors = 0;
	int tests_run = 0;

	two_wire_if bus ();

	always #5 I_CLOCK = ~I_CLOCK;
	// link clock offset by 3 ns; its edges still meet system clock edges at times such as 35 ns and 115 ns
	initial begin
		#3;
		forever #16 I_LINK_CLK = ~I_LINK_CLK;
	end

	eeprom_device #(.WRITE_CYCLES(WCYC)) i_eeprom_device (
		.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_LINK_CLK(I_LINK_CLK),
		.I_WRITE_PROTECT(wp), .I_CHIP_ENABLE_STRAPS(STRAPS),
		.O_BUSY(busy), .bus(bus));
	eeprom_master #(.QUARTER(20)) i_eeprom_master (
		.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_CMD_VALID(valid),
		.I_CMD_KIND(kind), .I_CMD_SEL(sel), .I_CMD_ADDR(addr),
		.I_CMD_LEN(len), .O_CMD_READY(ready), .I_WDATA(wdata),
		.O_WDATA_TAKE(take), .O_RDATA(rdata), .O_RDATA_VALID(rvalid),
		.O_NACK(nack), .O_DONE(done), .bus(bus));
	eeprom_link_sva #(.WRITE_CYCLES(WCYC)) i_eeprom_link_sva (
		.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .O_BUSY(busy),
		.m_sda_oe_n(bus.m_sda_oe_n), .d_sda_oe_n(bus.d_sda_oe_n),
		.scl(bus.scl), .sda(bus.sda));

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check_byte

	task automatic check_flag(input logic g, input logic e);
		check_byte({7'h00, g}, {7'h00, e});
	endtask : check_flag

	// one command, fed and collected at falling edges, bounded wait
	task automatic run_cmd(input logic [1:0] k, input logic [7:0] a,
		input logic [4:0] n);
		int i;
		int idx;
		i = 0;
		idx = 0;
		got.delete();
		@(negedge I_CLOCK);
		kind = k;
		addr = a;
		len = n;
		wdata = wbuf[0];
		valid = 1'b1;
		@(negedge I_CLOCK);
		valid = 1'b0;
		while (done !== 1'b1 && i < 40000) begin
			@(negedge I_CLOCK);
			i++;
			if (take === 1'b1) begin
				idx++;
				wdata = wbuf[idx % 16];
			end
			if (rvalid === 1'b1) got.push_back(rdata);
		end
		if (i >= 40000) begin
			num_errors++;
			results();
		end
	endtask : run_cmd

	task automatic t_page();
		int p;
		for (int j = 0; j < 16; j++) wbuf[j] = 8'hA0 + 8'(j * 7);
		run_cmd(CMD_WRITE, 8'hF0, 5'h10);
		check_flag(nack, 1'b0);
		check_flag(ready, 1'b1);
		run_cmd(CMD_POLL, 8'h00, 5'h00);
		check_flag(nack, 1'b1);
		p = 0;
		while (nack === 1'b1 && p < 20) begin
			run_cmd(CMD_POLL, 8'h00, 5'h00);
			p++;
		end
		check_flag(nack, 1'b0);
		$display("test page write and polling finished");
	endtask : t_page

	task automatic t_protect();
		wp = 1'b1;
		wbuf[0] = 8'h5A;
		wbuf[1] = 8'hC3;
		run_cmd(CMD_WRITE, 8'h00, 5'h01);
		check_flag(nack, 1'b1);
		// no write cycle may follow, so an immediate poll is answered
		run_cmd(CMD_POLL, 8'h00, 5'h00);
		check_flag(nack, 1'b0);
		$display("test protected write finished");
	endtask : t_protect

	task automatic t_reads();
		run_cmd(CMD_RANDOM_READ, 8'hFE, 5'h01);
		check_byte(got[0], 8'hA0 + 8'(14 * 7));
		check_byte(8'(got.size()), 8'h01);
		run_cmd(CMD_CURRENT_READ, 8'h00, 5'h01);
		check_byte(got[0], 8'hA0 + 8'(15 * 7));
		run_cmd(CMD_CURRENT_READ, 8'h00, 5'h02);
		check_byte(got[0], 8'h00);
		check_byte(got[1], 8'h00);
		run_cmd(CMD_RANDOM_READ, 8'hF0, 5'h10);
		check_byte(8'(got.size()), 8'h10);
		for (int j = 0; j < 16; j++) begin
			check_byte(got[j], 8'hA0 + 8'(j * 7));
		end
		wp = 1'b0;
		$display("test reads finished");
	endtask : t_reads

	task automatic t_select();
		sel = {`TYPE_ID, ~STRAPS};
		run_cmd(CMD_POLL, 8'h00, 5'h00);
		check_flag(nack, 1'b1);
		sel = {~(`TYPE_ID), STRAPS};
		run_cmd(CMD_POLL, 8'h00, 5'h00);
		check_flag(nack, 1'b1);
		sel = SEL;
		run_cmd(CMD_POLL, 8'h00, 5'h00);
		check_flag(nack, 1'b0);
		$display("test select matching finished");
	endtask : t_select

	initial begin
		repeat (20) @(negedge I_CLOCK);
		I_RST_N = 1'b1;
		repeat (10) @(negedge I_CLOCK);
		t_page();
		t_protect();
		t_reads();
		t_select();
		results();
	end
endmodule : serial_eeprom_page_write_read_bench
